// [common/clock_gate_pkg.sv]
// Constants, field layouts and carrier types for the peripheral clock gate.
// Assumes a 16-bit register port and one 50 MHz instruction clock.
package clock_gate_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_PERIPH = 32;
  localparam int SEL_W = 5;

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [ADDR_W-1:0] MODULE_DISABLE_FIRST_OFS = 16'h0770;
  localparam logic [ADDR_W-1:0] MODULE_DISABLE_SECOND_OFS = 16'h0772;
  localparam logic [DATA_W-1:0] MODULE_DISABLE_FIRST_RST = 16'h0000;
  localparam logic [DATA_W-1:0] MODULE_DISABLE_SECOND_RST = 16'h0000;

  // Bits that carry a peripheral; the others read zero
  localparam logic [DATA_W-1:0] FIRST_ASSIGNED = 16'hf9ff;
  localparam logic [DATA_W-1:0] SECOND_ASSIGNED = 16'hffff;

  // ****************************************************************
  // Field positions, first register (index 0..15 of the vector)
  // ****************************************************************
  localparam int CONVERTER_OFF = 0;
  localparam int CAN_CTRL1_OFF = 1;
  localparam int CAN_CTRL2_OFF = 2;
  localparam int SYNC_SERIAL1_OFF = 3;
  localparam int SYNC_SERIAL2_OFF = 4;
  localparam int SERIAL_PORT1_OFF = 5;
  localparam int SERIAL_PORT2_OFF = 6;
  localparam int TWO_WIRE_PORT_OFF = 7;
  localparam int CODEC_PORT_OFF = 8;
  localparam int TIMER1_OFF = 11;
  localparam int TIMER2_OFF = 12;
  localparam int TIMER3_OFF = 13;
  localparam int TIMER4_OFF = 14;
  localparam int TIMER5_OFF = 15;

  // Second register sits at index 16..31: compares low, captures high
  localparam int COMPARE1_OFF = 16;
  localparam int CAPTURE1_OFF = 24;

  // Gated enable reaches a peripheral this many cycles after the write
  localparam int GATE_DELAY_CYCLES = 1;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [SEL_W-1:0]  sel;
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } periph_req_s;

endpackage

// [core/gate_stage.sv]
// Register stage that turns allow bits into module clock enables.
// Assumes the disable bits change only on clock edges.
`timescale 1ns/1ps

module gate_stage
#(
  parameter int WIDTH = 32
)
(
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] allow_i,
  output logic      [WIDTH-1:0] enable_o
);

  logic [WIDTH-1:0] enable_reg;
  logic [WIDTH-1:0] enable_next;

  always_comb
  begin
    enable_next = allow_i;
  end

  // Starts cleared; present modules come up one cycle after release
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      enable_reg <= '0;
    else
      enable_reg <= enable_next;
  end

  assign enable_o = enable_reg;

endmodule // gate_stage

// [core/peripheral_clock_gate.sv]
// Peripheral module disable registers, clock enables and access gating.
// Assumes a one-cycle register port and peripherals whose register
// read data answer in the same cycle as a forwarded read.
`timescale 1ns/1ps

module peripheral_clock_gate
  import clock_gate_pkg::*;
#(
  parameter logic [DATA_W-1:0] PRESENT_FIRST  = FIRST_ASSIGNED,
  parameter logic [DATA_W-1:0] PRESENT_SECOND = SECOND_ASSIGNED
)
(
  input  wire logic                       clock_i,
  input  wire logic                       resetn_i,
  input  wire logic [clock_gate_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [clock_gate_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [clock_gate_pkg::DATA_W-1:0] rdata_o,
  input  wire logic [clock_gate_pkg::NUM_PERIPH-1:0] run_req_i,
  output logic      [clock_gate_pkg::NUM_PERIPH-1:0] clk_en_o,
  output logic      [clock_gate_pkg::NUM_PERIPH-1:0] run_o,
  input  wire clock_gate_pkg::periph_req_s periph_req_i,
  output clock_gate_pkg::periph_req_s      periph_req_o,
  input  wire logic [clock_gate_pkg::DATA_W-1:0] periph_rdata_i,
  output logic      [clock_gate_pkg::DATA_W-1:0] periph_rdata_o
);

  import clock_gate_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  function automatic logic unit_on(input logic [NUM_PERIPH-1:0] en,
                                   input logic [SEL_W-1:0] sel);
    unit_on = en[sel];
  endfunction

  localparam logic [DATA_W-1:0] FIRST_MASK = FIRST_ASSIGNED & PRESENT_FIRST;
  localparam logic [DATA_W-1:0] SECOND_MASK =
    SECOND_ASSIGNED & PRESENT_SECOND;
  localparam logic [NUM_PERIPH-1:0] PRESENT_ALL = {SECOND_MASK, FIRST_MASK};

  // ****************************************************************
  // Disable registers
  // ****************************************************************
  logic [DATA_W-1:0] dis_first_reg;
  logic [DATA_W-1:0] dis_first_next;
  logic [DATA_W-1:0] dis_second_reg;
  logic [DATA_W-1:0] dis_second_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [NUM_PERIPH-1:0] off_vec;
  logic [NUM_PERIPH-1:0] allow_vec;
  logic [NUM_PERIPH-1:0] clk_en_int;

  always_comb
  begin
    dis_first_next = dis_first_reg;
    dis_second_next = dis_second_reg;
    rdata_next = '0;
    // Unassigned and absent bits never store a one
    if (wr_i && reg_hit(addr_i, MODULE_DISABLE_FIRST_OFS))
      dis_first_next = wdata_i & FIRST_MASK;
    if (wr_i && reg_hit(addr_i, MODULE_DISABLE_SECOND_OFS))
      dis_second_next = wdata_i & SECOND_MASK;
    if (rd_i && reg_hit(addr_i, MODULE_DISABLE_FIRST_OFS))
      rdata_next = dis_first_reg;
    else if (rd_i && reg_hit(addr_i, MODULE_DISABLE_SECOND_OFS))
      rdata_next = dis_second_reg;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dis_first_reg <= MODULE_DISABLE_FIRST_RST;
      dis_second_reg <= MODULE_DISABLE_SECOND_RST;
      rdata_reg <= '0;
    end
    else
    begin
      dis_first_reg <= dis_first_next;
      dis_second_reg <= dis_second_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign off_vec = {dis_second_reg, dis_first_reg};
  assign allow_vec = ~off_vec & PRESENT_ALL;

  // ****************************************************************
  // Clock enables
  // ****************************************************************
  // The extra stage gives the one instruction cycle of settling so a
  // module never sees a clock cut in the same cycle as the write.
  gate_stage #(
    .WIDTH    (NUM_PERIPH)
  ) u_gate_stage (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .allow_i  (allow_vec),
    .enable_o (clk_en_int)
  );

  assign clk_en_o = clk_en_int;

  logic [NUM_PERIPH-1:0] run_reg;
  logic [NUM_PERIPH-1:0] run_next;

  always_comb
  begin
    run_next = allow_vec & run_req_i;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      run_reg <= '0;
    else
      run_reg <= run_next;
  end

  assign run_o = run_reg;

  // ****************************************************************
  // Peripheral register access gating
  // ****************************************************************
  periph_req_s       preq_reg;
  periph_req_s       preq_next;
  logic              rd_pend_reg;
  logic              rd_pend_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic              acc_ok;

  always_comb
  begin
    acc_ok = unit_on(clk_en_int, periph_req_i.sel);
    preq_next = periph_req_i;
    preq_next.wr = periph_req_i.wr & acc_ok;
    preq_next.rd = periph_req_i.rd & acc_ok;
    rd_pend_next = preq_next.rd;
    // Data only for a forwarded read; anything else answers zero
    prdata_next = rd_pend_reg ? periph_rdata_i : '0;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      preq_reg <= '0;
      rd_pend_reg <= 1'b0;
      prdata_reg <= '0;
    end
    else
    begin
      preq_reg <= preq_next;
      rd_pend_reg <= rd_pend_next;
      prdata_reg <= prdata_next;
    end
  end

  assign periph_req_o = preq_reg;
  assign periph_rdata_o = prdata_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_first_write;
    wr_i && reg_hit(addr_i, MODULE_DISABLE_FIRST_OFS);
  endsequence

  sequence s_gate_follows;
    ##2 clk_en_o[DATA_W-1:0] == (~$past(wdata_i, 2) & FIRST_MASK);
  endsequence

  sequence s_second_write;
    wr_i && reg_hit(addr_i, MODULE_DISABLE_SECOND_OFS);
  endsequence

  sequence s_upper_follows;
    ##2 clk_en_o[NUM_PERIPH-1:DATA_W] ==
      (~$past(wdata_i, 2) & SECOND_MASK);
  endsequence

  a_set_clock_stop: assert property (
    (clk_en_o & {off_vec}) == '0 || $changed(off_vec))
    else $error("clock runs for a disabled module");

  a_write_one_cycle: assert property (
    s_first_write |-> s_gate_follows)
    else $error("enable did not follow write after one cycle");

  a_blocked_access: assert property (
    (periph_req_i.wr || periph_req_i.rd) && !clk_en_o[periph_req_i.sel]
    |=> !periph_req_o.wr && !periph_req_o.rd)
    else $error("access forwarded to a disabled module");

  a_disabled_read_zero: assert property (
    periph_req_i.rd && !clk_en_o[periph_req_i.sel]
    |=> ##1 periph_rdata_o == '0)
    else $error("disabled module read gave data");

  a_absent_never_on: assert property (
    (clk_en_o & ~PRESENT_ALL) == '0 && (off_vec & ~PRESENT_ALL) == '0)
    else $error("absent or unassigned bit active");

  a_reset_all_on: assert property (
    disable iff (1'b0) $rose(resetn_i) |-> off_vec == '0 ##1
    clk_en_o == PRESENT_ALL)
    else $error("present modules not enabled after reset");

  // The edge that releases reset still loads zero, so skip that cycle
  a_restart_with_req: assert property (
    $past(resetn_i) |-> run_o == ($past(allow_vec) & $past(run_req_i)))
    else $error("run does not follow clear and request");

  a_second_one_cycle: assert property (
    s_second_write |-> s_upper_follows)
    else $error("upper enables did not follow write after one cycle");

  a_run_within_enable: assert property (
    (run_o & ~clk_en_o) == '0)
    else $error("module runs without its clock");

  a_first_read_back: assert property (
    rd_i && reg_hit(addr_i, MODULE_DISABLE_FIRST_OFS)
    |=> rdata_o == $past(dis_first_reg))
    else $error("first disable register read back wrong");

  a_reg_read_back: assert property (
    rd_i && reg_hit(addr_i, MODULE_DISABLE_SECOND_OFS)
    |=> rdata_o == $past(dis_second_reg) ##1 !$past(rd_i) |-> rdata_o == '0)
    else $error("disable register read back wrong");

endmodule // peripheral_clock_gate

// [testbench/peripheral_clock_gate_tb_top.sv]
// Self-checking bench for the peripheral clock gate.
// Assumes the one-cycle register port and the registered enables.
`timescale 1ns/1ps

module peripheral_clock_gate_tb_top;
  import clock_gate_pkg::*;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] d;
    logic [31:0] rq;
    logic [15:0] rb;
    logic [31:0] en;
  } row_s;

  logic        clock_i;
  logic        resetn_i;
  logic [15:0] addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [15:0] rdata_o;
  logic [31:0] run_req_i;
  logic [31:0] clk_en_o;
  logic [31:0] run_o;
  periph_req_s periph_req_i;
  periph_req_s periph_req_o;
  logic [15:0] periph_rdata_i;
  logic [15:0] periph_rdata_o;
  logic [15:0] m1;
  logic [15:0] m2;
  logic [15:0] q;
  logic [31:0] old;
  logic [31:0] exp_en;
  int          err_count;
  int          cmp_count;
  int          cyc = 0;
  row_s        rows [7];
  int          sels [6] = '{0, 1, 9, 11, 16, 17};

  assign exp_en = ~{m2, m1} & {SECOND_ASSIGNED, FIRST_ASSIGNED};

  peripheral_clock_gate peripheral_clock_gate_inst (
    .clock_i        (clock_i),
    .resetn_i       (resetn_i),
    .addr_i         (addr_i),
    .wdata_i        (wdata_i),
    .wr_i           (wr_i),
    .rd_i           (rd_i),
    .rdata_o        (rdata_o),
    .run_req_i      (run_req_i),
    .clk_en_o       (clk_en_o),
    .run_o          (run_o),
    .periph_req_i   (periph_req_i),
    .periph_req_o   (periph_req_o),
    .periph_rdata_i (periph_rdata_i),
    .periph_rdata_o (periph_rdata_o)
  );

  // ****************************************************************
  // Clock, timeout and verdict
  // ****************************************************************
  always #10 clock_i = ~clock_i;

  task automatic end_sim();
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Run needs under a hundred cycles; the ceiling leaves ample margin
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      $display("MISMATCH t=%0t timeout", $time);
      err_count++;
      end_sim();
    end
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [15:0] r);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 r = rdata_o;
  endtask

  // Disabled or absent modules must see no strobe, and a read of one must return zero data
  task automatic acc(input int s);
    periph_req_s p;
    periph_req_s e;
    logic        on;
    p       = '0;
    p.sel   = s[4:0];
    p.wr    = s[0];
    p.rd    = ~s[0];
    p.addr  = 16'h0100 + 16'(s);
    p.wdata = 16'h3c00 + 16'(s);
    on      = exp_en[s];
    e       = p;
    e.wr    = p.wr & on;
    e.rd    = p.rd & on;
    @(posedge clock_i);
    periph_req_i <= p;
    @(posedge clock_i);
    periph_req_i <= '0;
    #1 chk(40'(periph_req_o), 40'(e));
    @(posedge clock_i);
    #1 chk(40'(periph_rdata_o), (p.rd & on) ? 40'ha5c3 : 40'h0);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    clock_i = 1'b0;
    resetn_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    run_req_i = '0;
    periph_req_i = '0;
    periph_rdata_i = 16'ha5c3;
    m1 = '0;
    m2 = '0;
    err_count = 0;
    cmp_count = 0;
    // Columns: address, data, run request, read back, expected enables
    rows = '{'{16'h0770, 16'hffff, 32'hffffffff, 16'hf9ff, 32'hffff0000},
             '{16'h0772, 16'h00ff, 32'h5555aaaa, 16'h00ff, 32'hff000000},
             '{16'h0770, 16'h0000, 32'hffff0f0f, 16'h0000, 32'hff00f9ff},
             '{16'h0772, 16'hffff, 32'h0000ffff, 16'hffff, 32'h0000f9ff},
             '{16'h0774, 16'h1234, 32'hffffffff, 16'h0000, 32'h0000f9ff},
             '{16'h0770, 16'h0a01, 32'hffffffff, 16'h0801, 32'h0000f1fe},
             '{16'h0772, 16'h0000, 32'hffffffff, 16'h0000, 32'hfffff1fe}};
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    #1 chk(40'(clk_en_o), 40'(exp_en));
    reg_rd(MODULE_DISABLE_FIRST_OFS, q);
    chk(40'(q), 40'(MODULE_DISABLE_FIRST_RST));
    foreach (rows[i])
    begin
      @(posedge clock_i);
      run_req_i <= rows[i].rq;
      old = exp_en;
      reg_wr(rows[i].a, rows[i].d);
      if (rows[i].a == MODULE_DISABLE_FIRST_OFS)
        m1 = rows[i].d & FIRST_ASSIGNED;
      else if (rows[i].a == MODULE_DISABLE_SECOND_OFS)
        m2 = rows[i].d & SECOND_ASSIGNED;
      #1 chk(40'(clk_en_o), 40'(old));
      chk(40'(run_o), 40'(old & rows[i].rq));
      @(posedge clock_i);
      #1 chk(40'(clk_en_o), 40'(rows[i].en));
      chk(40'(run_o), 40'(rows[i].en & rows[i].rq));
      reg_rd(rows[i].a, q);
      chk(40'(q), 40'(rows[i].rb));
    end
    foreach (sels[i])
      acc(sels[i]);
    // Reset in mid-run must bring every present module back
    @(posedge clock_i);
    resetn_i <= 1'b0;
    #1 chk(40'(clk_en_o), 40'h0);
    chk(40'(run_o), 40'h0);
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    m1 = '0;
    m2 = '0;
    @(posedge clock_i);
    #1 chk(40'(clk_en_o), 40'(exp_en));
    reg_rd(MODULE_DISABLE_SECOND_OFS, q);
    chk(40'(q), 40'(MODULE_DISABLE_SECOND_RST));
    end_sim();
  end

endmodule // peripheral_clock_gate_tb_top
